// ### design/cst_pkg.sv
// Shared constants and types for the clock source select and trim block
package cst_pkg;

   // ------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------
   localparam logic [15:0] TRIM_ADDR = 16'h0096;
   localparam logic [15:0] DIV_ADDR = 16'h0095;
   localparam logic [15:0] AUX_ADDR = 16'h00a2;
   localparam logic [15:0] CTRL_ADDR = 16'hffde;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int TRIM_RC_SEL_BIT = 7;
   localparam int TRIM_OUT_EN_BIT = 6;
   localparam int AUX_LP_BIT = 7;
   localparam int CTRL_DONE_BIT = 7;
   localparam int CTRL_XWDOG_BIT = 4;
   localparam int CTRL_DBL_BIT = 3;
   localparam int CFG_B_DBL_BIT = 7;
   localparam logic [7:0] TRIM_RST = 8'h00;
   localparam logic [7:0] DIV_RST = 8'h00;
   localparam logic [2:0] SEL_RST = 3'h3;

   // ------------------------------------------------------------
   // Source select codes
   // ------------------------------------------------------------
   localparam logic [2:0] SEL_EXT = 3'h7;
   localparam logic [2:0] SEL_WDOG = 3'h4;
   localparam logic [2:0] SEL_RC = 3'h3;
   localparam logic [2:0] SEL_XLO = 3'h2;
   localparam logic [2:0] SEL_XMED = 3'h1;
   localparam logic [2:0] SEL_XHI = 3'h0;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int XTAL_OSC_CYC = 1024;
   localparam int SLOW_OSC_CYC = 32;
   localparam int XTAL_EXTRA_NS = 60000;
   localparam int RC_WAKE_NS = 200000;
   localparam int XTAL_EXTRA_CYC =
      (XTAL_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RC_WAKE_CYC =
      (RC_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LP_WIN_NS = 20000;
   localparam int LP_WIN_CYC = LP_WIN_NS / CLK_PERIOD_NS;
   localparam int LP_MAX_KHZ = 8000;
   localparam int LP_MAX_RISES = LP_MAX_KHZ * LP_WIN_NS / 1000000;

   // ------------------------------------------------------------
   // State and command types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {SW_IDLE, SW_OSC, SW_TIME} cst_sw_e;
   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_SET, OP_CLR} cst_op_e;
   typedef enum logic [1:0] {H_IDLE, H_RD, H_WR} cst_hs_e;

endpackage

// ### design/cst_if.sv
// Register bus and derived clocks between clock unit and processor core
`timescale 1ns/1ps
`default_nettype none
interface cst_if;
   logic rd;
   logic wr;
   logic xdata;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic rvalid;
   logic switch_done;
   logic cpu_slow;
   logic cpu_clock;
   logic periph_clock;
   logic machine_strobe;

   modport dev (
      input rd, wr, xdata, addr, wdata,
      output rdata, rvalid, switch_done, cpu_slow,
      output cpu_clock, periph_clock, machine_strobe
   );
   modport core (
      output rd, wr, xdata, addr, wdata,
      input rdata, rvalid, switch_done, cpu_slow,
      input cpu_clock, periph_clock, machine_strobe
   );
endinterface
`default_nettype wire

// ### design/cst_cpu_div.sv
// CPU clock divider: source clock divided by twice the divider value, undivided when the value is zero
`timescale 1ns/1ps
`default_nettype none
module cst_cpu_div
   import cst_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic src_rise_i,
   input wire logic src_edge_i,
   input wire logic [7:0] divider_i,
   output logic cpu_clock_o,
   output logic cpu_rise_o
);
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic next_clk;

   // ------------------------------------------------------------
   // Divider
   // ------------------------------------------------------------
   always_comb begin
      next_cnt = cnt;
      next_clk = cpu_clock_o;
      if (divider_i == 8'h00) begin
         // Undivided: follow every source edge
         next_cnt = 8'h00;
         if (src_edge_i) begin
            next_clk = ~cpu_clock_o;
         end
      end else if (src_rise_i) begin
         // Divider may change any time; counter keeps its count, and one at or past the new value toggles on the next rise
         if (cnt + 8'h01 >= divider_i) begin
            next_cnt = 8'h00;
            next_clk = ~cpu_clock_o;
         end else begin
            next_cnt = cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= 8'h00;
         cpu_clock_o <= 1'b0;
         cpu_rise_o <= 1'b0;
      end else begin
         cnt <= next_cnt;
         cpu_clock_o <= next_clk;
         cpu_rise_o <= next_clk & ~cpu_clock_o;
      end
   end
endmodule
`default_nettype wire

// ### design/cst_clock_unit.sv
// Clock source selection, trim, divider and clock switch unit
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Machine cycle spans two CPU clock periods
// - Peripheral clock is half the CPU clock
// - Source clock chosen from four sources
// - RC oscillator nominal, doubled when enabled
// - Crystal has low, medium, high ranges
// - Watchdog oscillator is low power source
// - Clock output only when crystal unused
// - Output enable bit drives half CPU clock
// - RC select bit overrides source immediately
// - Tune field loads factory value at reset
// - Tune field writable anytime, drives oscillator
// - Software keeps tune bits via read-modify-write
// - Doubler bit doubles RC oscillator output
// - Low power bit resets clear, slow only
// - Brownout reset hold needed for fast clocks
// - Source switch allowed while code runs
// - Switch done flag low while switching
// - Starting a switch clears done flag
// - No control writes while switch pending
// - Select and doubler load from config
// - Three-bit source select encoding
// - Wake-up delay per source kind
// - Divider gives source over twice N, undivided at N of zero
module cst_clock_unit
   import cst_pkg::*;
#(
   parameter int RC_WAKE_CYCLES = RC_WAKE_CYC
)
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   cst_if.dev bus,
   input wire logic rc_osc_i,
   input wire logic wdog_osc_i,
   input wire logic crystal_in_pin_i,
   input wire logic [5:0] trim_factory_i,
   input wire logic [7:0] user_config_byte_a_i,
   input wire logic [7:0] user_config_byte_b_i,
   input wire logic rtc_uses_crystal_i,
   output logic [5:0] rc_tune_o,
   output logic rc_doubler_o,
   output logic source_clock_o,
   output logic low_power_clock_bit_o,
   output logic crystal_out_pin_o,
   output logic crystal_out_pin_oe_o
);
   // ------------------------------------------------------------
   // Oscillator input sampling
   // ------------------------------------------------------------
   logic [2:0] osc_raw;
   logic [2:0] s1, s2, s3, lvl, lvl_prev, next_lvl;

   assign osc_raw = {crystal_in_pin_i, wdog_osc_i, rc_osc_i};

   always_comb begin
      // A change counts only once two late stages agree
      next_lvl = ((s2 ~^ s3) & s2) | ((s2 ^ s3) & lvl);
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1 <= 3'h0;
         s2 <= 3'h0;
         s3 <= 3'h0;
         lvl <= 3'h0;
         lvl_prev <= 3'h0;
      end else begin
         s1 <= osc_raw;
         s2 <= s1;
         s3 <= s2;
         lvl <= next_lvl;
         lvl_prev <= lvl;
      end
   end

   // Crystal and external clock share the crystal input pin
   function automatic logic [1:0] src_idx(input logic [2:0] sel);
      logic [1:0] idx;
      idx = 2'h2;
      if (sel == SEL_RC) idx = 2'h0;
      if (sel == SEL_WDOG) idx = 2'h1;
      return idx;
   endfunction

   function automatic logic is_xtal(input logic [2:0] sel);
      return (sel == SEL_XHI) || (sel == SEL_XMED) || (sel == SEL_XLO);
   endfunction

   function automatic logic valid_sel(input logic [2:0] sel);
      return is_xtal(sel) || (sel == SEL_RC) || (sel == SEL_WDOG) ||
         (sel == SEL_EXT);
   endfunction

   // ------------------------------------------------------------
   // Registers and clock switch
   // ------------------------------------------------------------
   logic init_pend, next_init_pend;
   logic [7:0] trim, next_trim;
   logic [7:0] div_val, next_div_val;
   logic lp, next_lp;
   logic dbl, next_dbl;
   logic xwdog, next_xwdog;
   logic [2:0] act_sel, next_act_sel, pend_sel, next_pend_sel;
   logic done, next_done;
   cst_sw_e sw_st, next_sw_st;
   logic [10:0] osc_cnt, next_osc_cnt;
   logic [13:0] time_cnt, next_time_cnt;
   logic [10:0] osc_target;
   logic [13:0] time_target;
   logic [7:0] next_rdata;
   logic next_rvalid;
   logic cpu_slow;
   logic sfr_wr, ctrl_wr, pend_rise;

   assign sfr_wr = bus.wr & ~bus.xdata & ~init_pend;
   assign ctrl_wr = bus.wr & bus.xdata & ~init_pend &
      (bus.addr == CTRL_ADDR);
   assign pend_rise = lvl[src_idx(pend_sel)] & ~lvl_prev[src_idx(pend_sel)];

   always_comb begin
      osc_target = 11'(SLOW_OSC_CYC);
      time_target = 14'h0000;
      if (is_xtal(pend_sel)) begin
         osc_target = 11'(XTAL_OSC_CYC);
         time_target = 14'(XTAL_EXTRA_CYC);
      end else if (pend_sel == SEL_RC) begin
         osc_target = 11'h000;
         time_target = 14'(RC_WAKE_CYCLES);
      end
   end

   always_comb begin
      next_init_pend = 1'b0;
      next_trim = trim;
      next_div_val = div_val;
      next_lp = lp;
      next_dbl = dbl;
      next_xwdog = xwdog;
      next_act_sel = act_sel;
      next_pend_sel = pend_sel;
      next_done = done;
      next_sw_st = sw_st;
      next_osc_cnt = osc_cnt;
      next_time_cnt = time_cnt;
      if (init_pend) begin
         next_trim[5:0] = trim_factory_i;
         next_act_sel = user_config_byte_a_i[2:0];
         next_pend_sel = user_config_byte_a_i[2:0];
         next_dbl = user_config_byte_b_i[CFG_B_DBL_BIT];
      end
      if (sfr_wr && bus.addr == TRIM_ADDR) begin
         next_trim = bus.wdata;
      end
      if (sfr_wr && bus.addr == DIV_ADDR) begin
         next_div_val = bus.wdata;
      end
      if (sfr_wr && bus.addr == AUX_ADDR) begin
         // Set only while the measured CPU clock is slow enough
         next_lp = bus.wdata[AUX_LP_BIT] & cpu_slow;
      end
      case (sw_st)
         SW_IDLE: begin
            // Busy writes are dropped; reserved codes are ignored
            if (ctrl_wr && done && valid_sel(bus.wdata[2:0])) begin
               next_dbl = bus.wdata[CTRL_DBL_BIT];
               next_xwdog = bus.wdata[CTRL_XWDOG_BIT];
               next_pend_sel = bus.wdata[2:0];
               next_done = 1'b0;
               next_osc_cnt = 11'h000;
               next_time_cnt = 14'h0000;
               next_sw_st = SW_OSC;
            end
         end
         SW_OSC: begin
            if (osc_cnt >= osc_target) begin
               next_sw_st = SW_TIME;
            end else if (pend_rise) begin
               next_osc_cnt = osc_cnt + 11'h001;
            end
         end
         SW_TIME: begin
            if (time_cnt >= time_target) begin
               // Divider runs from core clock, so the swap is glitch free
               next_act_sel = pend_sel;
               next_done = 1'b1;
               next_sw_st = SW_IDLE;
            end else begin
               next_time_cnt = time_cnt + 14'h0001;
            end
         end
         default: next_sw_st = SW_IDLE;
      endcase
   end

   always_comb begin
      next_rvalid = bus.rd;
      next_rdata = 8'h00;
      if (bus.rd && !bus.xdata && bus.addr == TRIM_ADDR) begin
         next_rdata = trim;
      end else if (bus.rd && !bus.xdata && bus.addr == DIV_ADDR) begin
         next_rdata = div_val;
      end else if (bus.rd && !bus.xdata && bus.addr == AUX_ADDR) begin
         next_rdata = {lp, 7'h00};
      end else if (bus.rd && bus.xdata && bus.addr == CTRL_ADDR) begin
         next_rdata = {done, 2'b00, xwdog, dbl, act_sel};
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         init_pend <= 1'b1;
         trim <= TRIM_RST;
         div_val <= DIV_RST;
         lp <= 1'b0;
         dbl <= 1'b0;
         xwdog <= 1'b0;
         act_sel <= SEL_RST;
         pend_sel <= SEL_RST;
         done <= 1'b1;
         sw_st <= SW_IDLE;
         osc_cnt <= 11'h000;
         time_cnt <= 14'h0000;
         bus.rdata <= 8'h00;
         bus.rvalid <= 1'b0;
      end else begin
         init_pend <= next_init_pend;
         trim <= next_trim;
         div_val <= next_div_val;
         lp <= next_lp;
         dbl <= next_dbl;
         xwdog <= next_xwdog;
         act_sel <= next_act_sel;
         pend_sel <= next_pend_sel;
         done <= next_done;
         sw_st <= next_sw_st;
         osc_cnt <= next_osc_cnt;
         time_cnt <= next_time_cnt;
         bus.rdata <= next_rdata;
         bus.rvalid <= next_rvalid;
      end
   end

   // ------------------------------------------------------------
   // Derived clocks
   // ------------------------------------------------------------
   logic [2:0] eff_sel;
   logic [1:0] eff_idx;
   logic cpu_rise, periph, next_periph, phase, next_phase, strobe;
   logic next_strobe, xtal_busy;

   assign eff_sel = trim[TRIM_RC_SEL_BIT] ? SEL_RC : act_sel;
   assign eff_idx = src_idx(eff_sel);
   assign source_clock_o = lvl[eff_idx];

   cst_cpu_div u_div (
      .core_clk_i (core_clk_i),
      .rst_n_i (rst_n_i),
      .src_rise_i (lvl[eff_idx] & ~lvl_prev[eff_idx]),
      .src_edge_i (lvl[eff_idx] ^ lvl_prev[eff_idx]),
      .divider_i (div_val),
      .cpu_clock_o (bus.cpu_clock),
      .cpu_rise_o (cpu_rise)
   );

   always_comb begin
      next_periph = periph ^ cpu_rise;
      next_phase = phase ^ cpu_rise;
      next_strobe = cpu_rise & phase;
   end

   // Crystal busy if it feeds CPU, watchdog or real-time clock
   assign xtal_busy = is_xtal(eff_sel) | xwdog | rtc_uses_crystal_i;

   // ------------------------------------------------------------
   // Low power eligibility window
   // ------------------------------------------------------------
   logic [9:0] win_cnt, next_win_cnt;
   logic [8:0] rise_cnt, next_rise_cnt;
   logic next_cpu_slow;

   always_comb begin
      next_cpu_slow = cpu_slow;
      next_win_cnt = win_cnt + 10'h001;
      next_rise_cnt = rise_cnt + {8'h00, cpu_rise};
      if (win_cnt == 10'(LP_WIN_CYC - 1)) begin
         next_cpu_slow = (next_rise_cnt <= 9'(LP_MAX_RISES));
         next_win_cnt = 10'h000;
         next_rise_cnt = 9'h000;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         periph <= 1'b0;
         phase <= 1'b0;
         strobe <= 1'b0;
         win_cnt <= 10'h000;
         rise_cnt <= 9'h000;
         cpu_slow <= 1'b0;
         crystal_out_pin_o <= 1'b0;
         crystal_out_pin_oe_o <= 1'b0;
      end else begin
         periph <= next_periph;
         phase <= next_phase;
         strobe <= next_strobe;
         win_cnt <= next_win_cnt;
         rise_cnt <= next_rise_cnt;
         cpu_slow <= next_cpu_slow;
         crystal_out_pin_o <= next_periph;
         crystal_out_pin_oe_o <= trim[TRIM_OUT_EN_BIT] & ~xtal_busy;
      end
   end

   assign bus.periph_clock = periph;
   assign bus.machine_strobe = strobe;
   assign bus.switch_done = done;
   assign bus.cpu_slow = cpu_slow;
   assign rc_tune_o = trim[5:0];
   // Analog oscillator doubles itself; frequencies are analog
   assign rc_doubler_o = dbl;
   assign low_power_clock_bit_o = lp;
endmodule
`default_nettype wire

// ### design/cst_core_end.sv
// Processor core end: register access with read-modify-write and guards
`timescale 1ns/1ps
`default_nettype none
module cst_core_end
   import cst_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   cst_if.core bus,
   input wire logic cmd_valid_i,
   input wire cst_op_e cmd_op_i,
   input wire logic cmd_xdata_i,
   input wire logic [15:0] cmd_addr_i,
   input wire logic [7:0] cmd_data_i,
   output logic cmd_ready_o,
   output logic rsp_valid_o,
   output logic [7:0] rsp_data_o
);
   cst_hs_e st, next_st;
   cst_op_e op, next_op;
   logic xd, next_xd, next_rd, next_wr, next_rsp_valid;
   logic [15:0] ad, next_ad;
   logic [7:0] dat, next_dat, next_wdata, next_rsp_data;

   assign cmd_ready_o = (st == H_IDLE);

   // ------------------------------------------------------------
   // Command sequencer
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_op = op;
      next_xd = xd;
      next_ad = ad;
      next_dat = dat;
      next_rd = 1'b0;
      next_wr = 1'b0;
      next_wdata = bus.wdata;
      next_rsp_valid = 1'b0;
      next_rsp_data = rsp_data_o;
      case (st)
         H_IDLE: begin
            if (cmd_valid_i) begin
               next_op = cmd_op_i;
               next_xd = cmd_xdata_i;
               next_ad = cmd_addr_i;
               next_dat = cmd_data_i;
               next_rd = (cmd_op_i != OP_WRITE);
               next_st = (cmd_op_i == OP_WRITE) ? H_WR : H_RD;
            end
         end
         H_RD: begin
            if (bus.rvalid) begin
               next_st = H_WR;
               // Bit updates keep the other bits, e.g. the tune field
               if (op == OP_SET) next_dat = bus.rdata | dat;
               if (op == OP_CLR) next_dat = bus.rdata & ~dat;
               if (op == OP_READ) begin
                  next_rsp_valid = 1'b1;
                  next_rsp_data = bus.rdata;
                  next_st = H_IDLE;
               end
            end
         end
         H_WR: begin
            // Hold a control write until the switch has finished
            if (!(xd && ad == CTRL_ADDR && !bus.switch_done)) begin
               next_wdata = dat;
               if (!xd && ad == AUX_ADDR && !bus.cpu_slow) begin
                  next_wdata[AUX_LP_BIT] = 1'b0;
               end
               next_wr = 1'b1;
               next_rsp_valid = 1'b1;
               next_rsp_data = next_wdata;
               next_st = H_IDLE;
            end
         end
         default: next_st = H_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= H_IDLE;
         op <= OP_READ;
         xd <= 1'b0;
         ad <= 16'h0000;
         dat <= 8'h00;
         bus.rd <= 1'b0;
         bus.wr <= 1'b0;
         bus.xdata <= 1'b0;
         bus.addr <= 16'h0000;
         bus.wdata <= 8'h00;
         rsp_valid_o <= 1'b0;
         rsp_data_o <= 8'h00;
      end else begin
         st <= next_st;
         op <= next_op;
         xd <= next_xd;
         ad <= next_ad;
         dat <= next_dat;
         bus.rd <= next_rd;
         bus.wr <= next_wr;
         bus.xdata <= next_xd;
         bus.addr <= next_ad;
         bus.wdata <= next_wdata;
         rsp_valid_o <= next_rsp_valid;
         rsp_data_o <= next_rsp_data;
      end
   end
endmodule
`default_nettype wire

// ### test/cst_asserts.sv
// Assertion checker on the bus between clock unit and core end
`timescale 1ns/1ps
`default_nettype none
module cst_asserts
   import cst_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic rd,
   input wire logic wr,
   input wire logic xdata,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   input wire logic switch_done,
   input wire logic cpu_clock,
   input wire logic periph_clock,
   input wire logic machine_strobe
);
   // Crystal wake-up at bench rates, with margin
   localparam int WAIT_MAX = 12500;
   logic armed, next_armed;
   logic [2:0] rises, next_rises;
   logic [13:0] wait_cnt, next_wait_cnt;
   logic cpu_prev, cpu_up;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // -----------------------------------------------
   // Helper counters
   // -----------------------------------------------
   always_comb begin
      cpu_up = cpu_clock & ~cpu_prev;
      next_armed = armed | machine_strobe;
      next_rises = machine_strobe ? 3'h0 : rises + {2'h0, cpu_up};
      next_wait_cnt = switch_done ? 14'h0 : wait_cnt + 14'h1;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         armed <= 1'b0;
         rises <= 3'h0;
         wait_cnt <= 14'h0;
         cpu_prev <= 1'b0;
      end else begin
         cpu_prev <= cpu_clock;
         armed <= next_armed;
         rises <= next_rises;
         wait_cnt <= next_wait_cnt;
      end
   end

   // -----------------------------------------------
   // Properties
   // -----------------------------------------------
   sequence ctrl_wr;
      wr && xdata && addr == CTRL_ADDR;
   endsequence
   sequence switch_start;
      ctrl_wr ##0 (switch_done && wdata[2:0] != 3'h5 && wdata[2:0] != 3'h6);
   endsequence

   AST_RD_ANSWER: assert property (rd |=> rvalid)
      else $error("read not answered next cycle");
   AST_DONE_READ: assert property (rd && xdata && addr == CTRL_ADDR |=>
      rdata[7] == $past(switch_done))
      else $error("done bit read differs from flag");
   AST_DONE_CLEAR: assert property (switch_start |=> !switch_done)
      else $error("switch start left done flag set");
   AST_NO_WR_PENDING: assert property (ctrl_wr |-> switch_done)
      else $error("control write during a switch");
   AST_DONE_MIN: assert property ($fell(switch_done) |-> !switch_done [*8])
      else $error("switch finished too early");
   AST_DONE_MAX: assert property (wait_cnt <= WAIT_MAX)
      else $error("switch exceeded wake-up bound");
   AST_PERIPH_HALF: assert property ($rose(cpu_clock) |->
      ##[0:2] $changed(periph_clock))
      else $error("peripheral clock missed a toggle");
   AST_MACHINE_CYC: assert property (armed && machine_strobe |->
      rises + {2'h0, $rose(cpu_clock)} == 3'h2)
      else $error("machine cycle not two cpu periods");
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench joining clock unit and core end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cst_pkg::*;
   logic core_clk_i = 0, rst_n_i = 0, rc = 0, wd = 0, xt = 0, rtc = 0;
   logic cv = 0, cx = 0, crdy, rv, dbl, lp, oe, pv, co;
   logic [5:0] fac = 6'h0, tune;
   logic [7:0] cfg_a = 8'h03, cfg_b = 8'h00, cd = 8'h0, rsp, rdat, et;
   logic [15:0] ca = 16'h0;
   logic [2:0] cur;
   logic [2:0] codes [0:6] = '{SEL_WDOG, SEL_EXT, SEL_XLO, 3'h5, SEL_XMED,
      SEL_XHI, SEL_RC};
   cst_op_e cop = OP_READ;
   integer seed = 32'h1a36;
   int miscompares = 0, n_tests = 0, n, cnt;

   cst_if ifc();
   always #10 core_clk_i = ~core_clk_i;
   // Oscillators: 7 cycles RC, 20 watchdog, 8 crystal
   always #70 rc = ~rc;
   always #200 wd = ~wd;
   always #80 xt = ~xt;

   cst_clock_unit #(.RC_WAKE_CYCLES(50)) cst_clock_unit_i (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus(ifc.dev),
      .rc_osc_i(rc), .wdog_osc_i(wd), .crystal_in_pin_i(xt),
      .trim_factory_i(fac), .user_config_byte_a_i(cfg_a),
      .user_config_byte_b_i(cfg_b), .rtc_uses_crystal_i(rtc),
      .rc_tune_o(tune), .rc_doubler_o(dbl), .source_clock_o(),
      .low_power_clock_bit_o(lp), .crystal_out_pin_o(co),
      .crystal_out_pin_oe_o(oe));
   cst_core_end cst_core_end_i (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus(ifc.core),
      .cmd_valid_i(cv), .cmd_op_i(cop), .cmd_xdata_i(cx), .cmd_addr_i(ca),
      .cmd_data_i(cd), .cmd_ready_o(crdy), .rsp_valid_o(rv),
      .rsp_data_o(rsp));
   cst_asserts cst_asserts_i (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .rd(ifc.rd), .wr(ifc.wr),
      .xdata(ifc.xdata), .addr(ifc.addr), .wdata(ifc.wdata),
      .rdata(ifc.rdata), .rvalid(ifc.rvalid),
      .switch_done(ifc.switch_done), .cpu_clock(ifc.cpu_clock),
      .periph_clock(ifc.periph_clock), .machine_strobe(ifc.machine_strobe));

   // ------------------------------------------------
   // Tasks and expectation functions
   // ------------------------------------------------
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      chk_byte({7'h0, g}, {7'h0, e});
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk_i);
      #1;
   endtask
   // Held until accepted; response awaited under a bound
   task automatic cmd(input cst_op_e op, input logic x,
         input logic [15:0] a, input logic [7:0] d);
      int k;
      k = 0;
      cop = op;
      cx = x;
      ca = a;
      cd = d;
      cv = 1'b1;
      while (crdy !== 1'b1) tick(1);
      tick(1);
      cv = 1'b0;
      while (rv !== 1'b1 && k < 20000) begin
         tick(1);
         k++;
      end
      if (k >= 20000) miscompares++;
      rdat = rsp;
   endtask
   task automatic rd_chk(input logic x, input logic [15:0] a,
         input logic [7:0] e);
      cmd(OP_READ, x, a, 8'h00);
      chk_byte(rdat, e);
   endtask
   task automatic do_reset();
      rst_n_i = 1'b0;
      tick(5);
      rst_n_i = 1'b1;
      tick(2);
   endtask
   // Nominal wake-up in core cycles at the bench's oscillator rates
   function automatic int wake_cyc(input logic [2:0] s);
      if (s == SEL_RC) return 50;
      if (s == SEL_WDOG) return 32 * 20;
      if (s == SEL_EXT) return 32 * 8;
      return 1024 * 8 + XTAL_EXTRA_CYC;
   endfunction
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial begin
      fac = 6'($random(seed));
      cfg_b[7] = 1'($random(seed));
      if (cfg_b[7]) cfg_a = 8'h2b;
      do_reset();
      et = {2'b00, fac};
      rd_chk(1'b0, TRIM_ADDR, et);
      rd_chk(1'b1, CTRL_ADDR, {4'h8, cfg_b[7], SEL_RC});
      chk_bit(dbl, cfg_b[7]);
      rd_chk(1'b0, AUX_ADDR, 8'h00);
      rd_chk(1'b0, 16'h0042, 8'h00);
      cmd(OP_SET, 1'b0, TRIM_ADDR, 8'h40);
      et[6] = 1'b1;
      chk_byte(rdat, et);
      tick(20);
      chk_bit(oe, 1'b1);
      chk_bit(co, ifc.periph_clock);
      rtc = 1'b1;
      tick(20);
      chk_bit(oe, 1'b0);
      rtc = 1'b0;
      for (int i = 0; i < 4; i++) begin
         et[5:0] = (i == 0) ? 6'h3f : 6'($random(seed));
         cmd(OP_WRITE, 1'b0, TRIM_ADDR, et);
         rd_chk(1'b0, TRIM_ADDR, et);
         chk_byte({2'b00, tune}, {2'b00, et[5:0]});
      end
      cmd(OP_SET, 1'b0, TRIM_ADDR, 8'h80);
      chk_byte(rdat, et | 8'h80);
      cmd(OP_CLR, 1'b0, TRIM_ADDR, 8'h80);
      chk_byte(rdat, et);
      cur = SEL_RC;
      foreach (codes[i]) begin
         cmd(OP_WRITE, 1'b1, CTRL_ADDR, {4'h0, cfg_b[7], codes[i]});
         if (codes[i] != 3'h5) begin
            cur = codes[i];
            cmd(OP_READ, 1'b1, CTRL_ADDR, 8'h00);
            chk_bit(rdat[7], 1'b0);
            n = 0;
            while (ifc.switch_done !== 1'b1 && n < 20000) begin
               tick(1);
               n++;
            end
            chk_bit(n + 40 >= wake_cyc(cur), 1'b1);
            chk_bit(n <= wake_cyc(cur) + 20, 1'b1);
         end
         rd_chk(1'b1, CTRL_ADDR, {4'h8, cfg_b[7], cur});
         if (cur < 3'h3) chk_bit(oe, 1'b0);
      end
      // Only the RC rate is exact enough for counting cpu rises
      for (int nd = 0; nd < 4; nd += 3) begin
         cmd(OP_WRITE, 1'b0, DIV_ADDR, 8'(nd));
         tick(10);
         cnt = 0;
         pv = ifc.cpu_clock;
         repeat (588) begin
            tick(1);
            if (ifc.cpu_clock === 1'b1 && pv === 1'b0) cnt++;
            pv = ifc.cpu_clock;
         end
         chk_bit(cnt >= (nd == 0 ? 83 : 13) && cnt <= (nd == 0 ? 85 : 15),
            1'b1);
      end
      tick(2200);
      cmd(OP_WRITE, 1'b0, AUX_ADDR, 8'h80);
      rd_chk(1'b0, AUX_ADDR, 8'h80);
      chk_bit(lp, 1'b1);
      do_reset();
      rd_chk(1'b0, AUX_ADDR, 8'h00);
      rd_chk(1'b0, TRIM_ADDR, {2'b00, fac});
      final_report();
   end

   initial begin
      #1600000;
      miscompares++;
      final_report();
   end
endmodule
`default_nettype wire
